// ---- verilog/gpm_top.sv ----
// Functional notes
// - Seven identical port blocks, each with its own configuration and data.
// - Cleared digital enable sends pin to analog path, digital input off.
// - Alternate function only with select, digital enable and matching code.
// - Each pin's mux code and select bits affect that pin alone.
// - Default pins reset as tri-stated software I/O, all controls clear except 2 mA drive set.
// - Port A 1:0, 5:2 reset to serial functions; port C 3:0 to debug.
// - Four debug pins reset configured for the debug function.
// - Any reset returns every pin, exceptions too, to its default.
// - Output pin can change every two clocks from software writes.
// - Per-pin edge interrupt on rising, falling or both edges.
// - Per-pin level interrupt on high or low input level.
// - Per-pin interrupt mask gates detected conditions from the output.
// - Port data reads and writes masked bit by bit by address lines.
// - Per-pin pull, drive 2/4/8 mA, slew at 8 mA, open drain, input enable.
// - Direction clear captures input into data; set drives data out.
// - Data write alters only bits whose address bit 9:2 is set.
// - Data read returns zero for bits whose address bit is clear.
// - One interrupt per port; edge interrupts pend until cleared.
`timescale 1ns/1ps
module gpm_top (
    // Clock and reset
    input  wire  logic                      pclk,
    input  wire  logic                      presetn,
    // APB slave
    input  wire  logic                      psel,
    input  wire  logic                      penable,
    input  wire  logic                      pwrite,
    input  wire  logic [15:0]               paddr,
    input  wire  logic [31:0]               pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Pads
    input  wire  logic [6:0][7:0]           pad_in,
    output logic [6:0][7:0]                 pad_out,
    output logic [6:0][7:0]                 pad_oe,
    output gpm_pkg::gpm_pad_ctrl_t [6:0]    pad_ctrl,
    output logic [6:0][7:0]                 analog_en,
    // Peripheral side of the mux
    input  wire  gpm_pkg::gpm_alt_t [6:0]   alt_out,
    input  wire  gpm_pkg::gpm_alt_t [6:0]   alt_oe,
    output gpm_pkg::gpm_alt_t [6:0]         alt_in,
    // Interrupts, one per port
    output logic [6:0]                      irq
);
    import gpm_pkg::*;

    logic [31:0] rd_word [NPORT];
    logic        rd_hit  [NPORT];
    logic [31:0] prdata_reg;
    logic        pslverr_reg;

    wire [2:0]  port_sel = paddr[14:12];
    wire [11:0] offset   = {paddr[OFF_MSB:OFF_LSB], 2'b00};
    wire [7:0]  bit_mask = paddr[MASK_MSB:MASK_LSB];
    wire        is_data  = paddr[11:10] == DATA_REGION;
    wire        setup    = psel && !penable;
    wire        access   = psel && penable;
    wire        wr_en    = access && pwrite;
    wire        port_ok  = port_sel <= PORT_LAST;
    wire        lo_zero  = paddr[1:0] == 2'b00 && paddr[15] == 1'b0;
    wire [31:0] rd_sel   = port_ok ? rd_word[port_sel] : 32'h0;
    wire        hit_sel  = port_ok && lo_zero && rd_hit[port_sel];

    // No wait states, which is what lets a pin toggle every two clocks
    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg && access;

    // Read data latched in setup so it comes from a flop in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg  <= pwrite ? 32'h0 : rd_sel;
            pslverr_reg <= !hit_sel;
        end
    end

    genvar p, b;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            logic [7:0]  dir_reg, is_reg, ibe_reg, iev_reg, im_reg;
            logic [7:0]  ris_reg, afsel_reg, odr_reg, slr_reg, den_reg;
            logic [7:0]  dr2_reg, dr4_reg, dr8_reg, pur_reg, pdr_reg;
            logic [7:0]  data_reg, prev_reg;
            logic [31:0] pctl_reg;
            logic [7:0]  ris_next, data_next, evt, din, alt_on;
            logic [31:0] rd_l;
            logic        hit_l;

            wire        we = wr_en && port_sel == p && lo_zero;
            wire [7:0]  wd = pwdata[7:0];
            wire        we_data = we && is_data;
            wire [7:0]  w_icr = (we && offset == OFF_ICR) ? wd : 8'h0;
            wire [7:0]  w2 = (we && offset == OFF_DR2) ? wd : 8'h0;
            wire [7:0]  w4 = (we && offset == OFF_DR4) ? wd : 8'h0;
            wire [7:0]  w8 = (we && offset == OFF_DR8) ? wd : 8'h0;
            wire [7:0]  wu = (we && offset == OFF_PUR) ? wd : 8'h0;
            wire [7:0]  wdn = (we && offset == OFF_PDR) ? wd : 8'h0;

            // Input path is dead while the pin is analog
            assign din = pad_in[p] & den_reg;
            assign analog_en[p] = ~den_reg;
            assign alt_on = afsel_reg & den_reg;

            // Edge or level detect per pin
            assign evt = is_reg & ~(din ^ iev_reg)
                       | ~is_reg & ((din ^ prev_reg)
                       & (ibe_reg | ~(din ^ iev_reg)));
            // Set wins over a clear in the same cycle
            assign ris_next = (ris_reg & ~w_icr) | evt;
            assign irq[p] = |(ris_reg & im_reg);

            // Inputs follow the pad, outputs take only masked writes
            assign data_next = (~dir_reg & din)
                | (dir_reg & (we_data
                    ? (data_reg & ~bit_mask) | (wd & bit_mask)
                    : data_reg));

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    data_reg <= RST_ZERO;
                    prev_reg <= RST_ZERO;
                    ris_reg  <= RST_ZERO;
                end else begin
                    data_reg <= data_next;
                    prev_reg <= din;
                    ris_reg  <= ris_next;
                end
            end

            // Exception pins come back on every reset, not only power-up
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    afsel_reg <= RST_AFSEL[p];
                    den_reg   <= RST_DEN[p];
                    pur_reg   <= RST_PUR[p];
                    pctl_reg  <= RST_PCTL[p];
                    pdr_reg   <= RST_ZERO;
                end else begin
                    if (we && offset == OFF_AFSEL) afsel_reg <= wd;
                    if (we && offset == OFF_DEN) den_reg <= wd;
                    if (we && offset == OFF_PCTL) pctl_reg <= pwdata;
                    // Pull up and pull down are exclusive
                    pur_reg <= (pur_reg & ~wdn) | wu;
                    pdr_reg <= (pdr_reg & ~wu) | wdn;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dir_reg <= RST_ZERO;
                    is_reg  <= RST_ZERO;
                    ibe_reg <= RST_ZERO;
                    iev_reg <= RST_ZERO;
                    im_reg  <= RST_ZERO;
                    odr_reg <= RST_ZERO;
                    slr_reg <= RST_ZERO;
                end else if (we) begin
                    if (offset == OFF_DIR) dir_reg <= wd;
                    if (offset == OFF_IS)  is_reg  <= wd;
                    if (offset == OFF_IBE) ibe_reg <= wd;
                    if (offset == OFF_IEV) iev_reg <= wd;
                    if (offset == OFF_IM)  im_reg  <= wd;
                    if (offset == OFF_ODR) odr_reg <= wd;
                    if (offset == OFF_SLR) slr_reg <= wd;
                end
            end

            // Setting one drive strength clears the other two
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dr2_reg <= RST_DR2;
                    dr4_reg <= RST_ZERO;
                    dr8_reg <= RST_ZERO;
                end else begin
                    dr2_reg <= (dr2_reg & ~w4 & ~w8) | w2;
                    dr4_reg <= (dr4_reg & ~w2 & ~w8) | w4;
                    dr8_reg <= (dr8_reg & ~w2 & ~w4) | w8;
                end
            end

            assign pad_ctrl[p] = '{pull_up: pur_reg, pull_down: pdr_reg,
                drv_2ma: dr2_reg, drv_4ma: dr4_reg, drv_8ma: dr8_reg,
                slew_ctl: slr_reg & dr8_reg,
                open_drain: odr_reg, dig_en: den_reg};

            for (b = 0; b < NPIN; b++) begin : g_pin
                wire [3:0] code = pctl_reg[4*b +: CODE_W];
                wire       a_o  = alt_out[p][b][code];
                wire       a_e  = alt_oe[p][b][code];
                wire       v_o  = alt_on[b] ? a_o : data_reg[b];
                wire       v_e  = alt_on[b] ? a_e : dir_reg[b];
                // Open drain only ever pulls low
                assign pad_out[p][b] = odr_reg[b] ? 1'b0 : v_o;
                assign pad_oe[p][b]  = odr_reg[b] ? v_e & ~v_o : v_e;
                assign alt_in[p][b] = alt_on[b]
                    ? (NCODE'(din[b]) << code) : '0;
            end

            always_comb begin
                rd_l  = 32'h0;
                hit_l = 1'b1;
                if (is_data) begin
                    rd_l = {24'h0, data_reg & bit_mask};
                end else begin
                    unique case (offset)
                        OFF_DIR:   rd_l = {24'h0, dir_reg};
                        OFF_IS:    rd_l = {24'h0, is_reg};
                        OFF_IBE:   rd_l = {24'h0, ibe_reg};
                        OFF_IEV:   rd_l = {24'h0, iev_reg};
                        OFF_IM:    rd_l = {24'h0, im_reg};
                        OFF_RIS:   rd_l = {24'h0, ris_reg};
                        OFF_MIS:   rd_l = {24'h0, ris_reg & im_reg};
                        OFF_ICR:   rd_l = 32'h0;
                        OFF_AFSEL: rd_l = {24'h0, afsel_reg};
                        OFF_DR2:   rd_l = {24'h0, dr2_reg};
                        OFF_DR4:   rd_l = {24'h0, dr4_reg};
                        OFF_DR8:   rd_l = {24'h0, dr8_reg};
                        OFF_ODR:   rd_l = {24'h0, odr_reg};
                        OFF_PUR:   rd_l = {24'h0, pur_reg};
                        OFF_PDR:   rd_l = {24'h0, pdr_reg};
                        OFF_SLR:   rd_l = {24'h0, slr_reg};
                        OFF_DEN:   rd_l = {24'h0, den_reg};
                        OFF_PCTL:  rd_l = pctl_reg;
                        default:   hit_l = 1'b0;
                    endcase
                end
            end
            assign rd_word[p] = rd_l;
            assign rd_hit[p]  = hit_l;

            // Checks on this port
            property p_reset_cfg;
                @(posedge pclk) disable iff (!presetn)
                $rose(presetn) |-> afsel_reg == RST_AFSEL[p]
                    && den_reg == RST_DEN[p] && pur_reg == RST_PUR[p]
                    && pctl_reg == RST_PCTL[p] && pdr_reg == RST_ZERO;
            endproperty
            a_reset_cfg: assert property (p_reset_cfg)
                else $error("Port configuration not at reset default");

            property p_mask_write;
                @(posedge pclk) disable iff (!presetn)
                we_data |=> ((data_reg ^ $past(data_reg))
                    & $past(dir_reg) & ~$past(bit_mask)) == 8'h0;
            endproperty
            a_mask_write: assert property (p_mask_write)
                else $error("Masked data bit changed on write");

            sequence s_rise0;
                !is_reg[0] && iev_reg[0] && din[0] && !prev_reg[0];
            endsequence
            property p_edge_rise;
                @(posedge pclk) disable iff (!presetn)
                s_rise0 |=> ris_reg[0] ##1 (ris_reg[0] || $past(w_icr[0]));
            endproperty
            a_edge_rise: assert property (p_edge_rise)
                else $error("Rising edge did not latch status");

            property p_level_hi;
                @(posedge pclk) disable iff (!presetn)
                (is_reg[0] && iev_reg[0] && din[0]) |=> ris_reg[0];
            endproperty
            a_level_hi: assert property (p_level_hi)
                else $error("High level did not set status");

            property p_irq_mask;
                @(posedge pclk) disable iff (!presetn)
                (ris_reg & im_reg) == 8'h0 |-> !irq[p];
            endproperty
            a_irq_mask: assert property (p_irq_mask)
                else $error("Interrupt raised with all causes masked");

            property p_pending;
                @(posedge pclk) disable iff (!presetn)
                (ris_reg[0] && !w_icr[0]) |=> ris_reg[0];
            endproperty
            a_pending: assert property (p_pending)
                else $error("Pending status lost without clear");

            property p_toggle;
                @(posedge pclk) disable iff (!presetn)
                (we_data && bit_mask[0] && dir_reg[0] && !alt_on[0]
                    && !odr_reg[0]) |=> pad_out[p][0] == $past(wd[0]);
            endproperty
            a_toggle: assert property (p_toggle)
                else $error("Pad did not follow data write");

            property p_analog;
                @(posedge pclk) disable iff (!presetn)
                !den_reg[3] |-> analog_en[p][3] && alt_in[p][3] == '0
                    ##1 !evt[3] || den_reg[3] || is_reg[3];
            endproperty
            a_analog: assert property (p_analog)
                else $error("Analog pin still feeds digital logic");

            property p_drive_one;
                @(posedge pclk) disable iff (!presetn)
                $changed(dr8_reg) |-> (dr2_reg & dr8_reg) == 8'h0
                    && (dr4_reg & dr8_reg) == 8'h0;
            endproperty
            a_drive_one: assert property (p_drive_one)
                else $error("Two drive strengths selected at once");

            property p_pull_one;
                @(posedge pclk) disable iff (!presetn)
                ($changed(pur_reg) || $changed(pdr_reg))
                    |-> (pur_reg & pdr_reg) == 8'h0;
            endproperty
            a_pull_one: assert property (p_pull_one)
                else $error("Pull-up and pull-down both selected");

            // Open drain may only sink, never source current
            property p_open_drain;
                @(posedge pclk) disable iff (!presetn)
                (odr_reg[0] && !alt_on[0]) |-> !pad_out[p][0]
                    && pad_oe[p][0] == (dir_reg[0] && !data_reg[0]);
            endproperty
            a_open_drain: assert property (p_open_drain)
                else $error("Open drain pin driven high");

            property p_clear;
                @(posedge pclk) disable iff (!presetn)
                (w_icr[0] && !evt[0]) |=> !ris_reg[0];
            endproperty
            a_clear: assert property (p_clear)
                else $error("Status bit not cleared by write");
        end
    endgenerate

    property p_read_mask;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && is_data && port_ok && lo_zero)
            |=> (prdata & ~{24'h0, $past(bit_mask)}) == 32'h0;
    endproperty
    a_read_mask: assert property (p_read_mask)
        else $error("Unmasked data bit returned on read");

    // A missing port must answer with an error, not drop silently
    sequence s_bad_setup;
        setup && !port_ok;
    endsequence
    property p_refused;
        @(posedge pclk) disable iff (!presetn)
        s_bad_setup ##1 access |-> pslverr;
    endproperty
    a_refused: assert property (p_refused)
        else $error("Access to a missing port not refused");
endmodule : gpm_top

// ---- verilog/gpm_pkg.sv ----
package gpm_pkg;
    localparam int NPORT  = 7;
    localparam int NPIN   = 8;
    localparam int CODE_W = 4;
    localparam int NCODE  = 16;
    localparam int PSEL_LSB = 12;
    localparam int OFF_LSB  = 2;
    localparam int OFF_MSB  = 11;
    localparam int MASK_LSB = 2;
    localparam int MASK_MSB = 9;
    localparam logic [2:0] PORT_LAST = 3'h6;
    localparam logic [1:0] DATA_REGION = 2'h0;

    // Byte offsets of the control registers inside one port
    localparam logic [11:0] OFF_DIR   = 12'h400;
    localparam logic [11:0] OFF_IS    = 12'h404;
    localparam logic [11:0] OFF_IBE   = 12'h408;
    localparam logic [11:0] OFF_IEV   = 12'h40c;
    localparam logic [11:0] OFF_IM    = 12'h410;
    localparam logic [11:0] OFF_RIS   = 12'h414;
    localparam logic [11:0] OFF_MIS   = 12'h418;
    localparam logic [11:0] OFF_ICR   = 12'h41c;
    localparam logic [11:0] OFF_AFSEL = 12'h420;
    localparam logic [11:0] OFF_DR2   = 12'h500;
    localparam logic [11:0] OFF_DR4   = 12'h504;
    localparam logic [11:0] OFF_DR8   = 12'h508;
    localparam logic [11:0] OFF_ODR   = 12'h50c;
    localparam logic [11:0] OFF_PUR   = 12'h510;
    localparam logic [11:0] OFF_PDR   = 12'h514;
    localparam logic [11:0] OFF_SLR   = 12'h518;
    localparam logic [11:0] OFF_DEN   = 12'h51c;
    localparam logic [11:0] OFF_PCTL  = 12'h52c;

    // Reset values, index 0 is port A, index 2 is port C
    localparam logic [6:0][7:0] RST_AFSEL =
        {8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h3f};
    localparam logic [6:0][7:0] RST_DEN =
        {8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h3f};
    localparam logic [6:0][7:0] RST_PUR =
        {8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00};
    localparam logic [6:0][31:0] RST_PCTL =
        {32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_3333, 32'h0,
         32'h0011_1111};
    localparam logic [7:0] RST_DR2  = 8'hff;
    localparam logic [7:0] RST_ZERO = 8'h00;

    typedef struct packed {
        logic [7:0] pull_up;
        logic [7:0] pull_down;
        logic [7:0] drv_2ma;
        logic [7:0] drv_4ma;
        logic [7:0] drv_8ma;
        logic [7:0] slew_ctl;
        logic [7:0] open_drain;
        logic [7:0] dig_en;
    } gpm_pad_ctrl_t;

    typedef logic [NPIN-1:0][NCODE-1:0] gpm_alt_t;
endpackage : gpm_pkg

// ---- verif/gpm_pin_model.sv ----
`timescale 1ns/1ps
module gpm_pin_model (
    // Clock
    input  wire  logic                          pclk,
    // Pad side of the port logic
    input  wire  logic [6:0][7:0]               pad_out,
    input  wire  logic [6:0][7:0]               pad_oe,
    input  wire  gpm_pkg::gpm_pad_ctrl_t [6:0]  pad_ctrl,
    output logic [6:0][7:0]                     pad_in,
    // Outside drivers set by the bench
    input  wire  logic [6:0][7:0]               ext_val,
    input  wire  logic [6:0][7:0]               ext_oe,
    // Peripherals behind the mux
    output gpm_pkg::gpm_alt_t [6:0]             alt_out,
    output gpm_pkg::gpm_alt_t [6:0]             alt_oe
);
    import gpm_pkg::*;

    // Undriven pins toggle so a stale level never passes for data
    logic [6:0][7:0] float_reg = '0;

    always @(posedge pclk) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int p = 0; p < 7; p++) begin
            for (int n = 0; n < 8; n++) begin
                if (pad_oe[p][n])
                    pad_in[p][n] = pad_out[p][n];
                else if (ext_oe[p][n])
                    pad_in[p][n] = ext_val[p][n];
                else if (pad_ctrl[p].pull_up[n])
                    pad_in[p][n] = 1'b1;
                else if (pad_ctrl[p].pull_down[n])
                    pad_in[p][n] = 1'b0;
                else
                    pad_in[p][n] = float_reg[p][n];
                // Each code carries its own level, so a wrong pick shows
                for (int c = 0; c < NCODE; c++) begin
                    alt_oe[p][n][c]  = 1'b1;
                    alt_out[p][n][c] = 1'((p + n + c) % 2);
                end
            end
        end
    end
endmodule : gpm_pin_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import gpm_pkg::*;

    typedef struct {
        logic        wr;
        logic [2:0]  port;
        logic [11:0] off;
        logic [31:0] data;
        logic [31:0] exp;
    } gpm_row_t;

    logic                  pclk, presetn, psel, penable, pwrite;
    logic [15:0]           paddr;
    logic [31:0]           pwdata, prdata;
    logic                  pready, pslverr;
    logic [6:0][7:0]       pad_in, pad_out, pad_oe, analog_en;
    logic [6:0][7:0]       ext_val, ext_oe;
    gpm_pad_ctrl_t [6:0]   pad_ctrl;
    gpm_alt_t [6:0]        alt_out, alt_oe, alt_in;
    logic [6:0]            irq;
    int                    errors, checks, cycles;
    logic [31:0]           rdat;
    logic                  rerr;
    logic [2:0]            modes [5];
    logic                  starts [5];

    gpm_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_ctrl(pad_ctrl), .analog_en(analog_en),
        .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in), .irq(irq));

    gpm_pin_model pins (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_ctrl(pad_ctrl), .pad_in(pad_in), .ext_val(ext_val),
        .ext_oe(ext_oe), .alt_out(alt_out), .alt_oe(alt_oe));

    gpm_row_t rows [18] = '{
        '{1'b0, 3'h0, OFF_AFSEL, 32'h0, 32'h3f},
        '{1'b0, 3'h0, OFF_DEN, 32'h0, 32'h3f},
        '{1'b0, 3'h0, OFF_PCTL, 32'h0, 32'h0011_1111},
        '{1'b0, 3'h2, OFF_AFSEL, 32'h0, 32'h0f},
        '{1'b0, 3'h2, OFF_DEN, 32'h0, 32'h0f},
        '{1'b0, 3'h2, OFF_PUR, 32'h0, 32'h0f},
        '{1'b0, 3'h2, OFF_PCTL, 32'h0, 32'h3333},
        '{1'b0, 3'h1, OFF_AFSEL, 32'h0, 32'h0},
        '{1'b0, 3'h3, OFF_PDR, 32'h0, 32'h0},
        '{1'b0, 3'h4, OFF_PCTL, 32'h0, 32'h0},
        '{1'b0, 3'h6, OFF_DEN, 32'h0, 32'h0},
        '{1'b0, 3'h5, OFF_DIR, 32'h0, 32'h0},
        '{1'b1, 3'h6, OFF_DR8, 32'h02, 32'h02},
        '{1'b1, 3'h6, OFF_DR2, 32'h0, 32'hfd},
        '{1'b1, 3'h6, OFF_PDR, 32'h04, 32'h04},
        '{1'b1, 3'h6, OFF_PUR, 32'h04, 32'h04},
        '{1'b1, 3'h6, OFF_PDR, 32'h0, 32'h0},
        '{1'b1, 3'h6, OFF_SLR, 32'h02, 32'h02}};

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    // Zero wait is promised, yet the loop still waits on pready
    // Hold keeps psel up for the next setup; follow is that setup
    task apb(input logic wr, input logic [2:0] port,
             input logic [11:0] off, input logic [31:0] wd,
             input logic hold = 1'b0, input logic follow = 1'b0);
        if (!follow) begin
            @(posedge pclk);
            psel <= 1'b1;
        end
        pwrite  <= wr;
        paddr   <= {1'b0, port, off};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        if (!hold)
            psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd_chk(input logic [2:0] port, input logic [11:0] off,
                input logic [31:0] exp);
        apb(1'b0, port, off, 32'h0);
        check(rdat, exp);
    endtask : rd_chk

    task do_reset;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end

    initial begin
        errors = 0;
        checks = 0;
        cycles = 0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 16'h0;
        pwdata = 32'h0;
        ext_oe = '0;
        ext_val = '0;
        ext_oe[3] = 8'hff;
        ext_val[3] = 8'ha5;
        ext_oe[5] = 8'h01;
        modes = '{3'h1, 3'h0, 3'h2, 3'h5, 3'h4};
        starts = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        do_reset();
        #1 check(pad_oe[0], 8'h3f);
        check(pad_oe[2], 8'h0f);
        check(pad_oe[1], 8'h00);
        check(analog_en[3], 8'hff);
        check(irq, 7'h0);
        foreach (rows[i]) begin
            if (rows[i].wr)
                apb(1'b1, rows[i].port, rows[i].off, rows[i].data);
            rd_chk(rows[i].port, rows[i].off, rows[i].exp);
        end
        #1 check(pad_ctrl[6].slew_ctl, 8'h02);
        check(pad_ctrl[6].drv_2ma, 8'hfd);
        check(pad_ctrl[6].pull_up, 8'h04);
        // Full clear, one masked write, full write, then a masked read
        apb(1'b1, 3'h1, OFF_DIR, 32'hff);
        apb(1'b1, 3'h1, 12'h3fc, 32'h0);
        apb(1'b1, 3'h1, 12'h098, 32'heb);
        #1 check(pad_out[1], 8'h22);
        check(pad_oe[1], 8'hff);
        apb(1'b1, 3'h1, 12'h3fc, 32'hff);
        #1 check(pad_out[1], 8'hff);
        rd_chk(3'h1, 12'h0c4, 32'h31);
        // Back to back, so the pad changes on every second clock
        apb(1'b1, 3'h1, 12'h3fc, 32'h05, 1'b1);
        apb(1'b1, 3'h1, 12'h3c0, 32'ha0, 1'b0, 1'b1);
        #1 check(pad_out[1], 8'ha5);
        // Open drain releases a high bit instead of driving it
        apb(1'b1, 3'h1, OFF_ODR, 32'h01);
        #1 check({pad_oe[1], pad_out[1]}, 16'hfea4);
        // Input capture once digital path is on
        apb(1'b1, 3'h3, OFF_DEN, 32'hff);
        repeat (4) @(posedge pclk);
        rd_chk(3'h3, 12'h3fc, 32'ha5);
        #1 check(analog_en[3], 8'h00);
        // Alternate code 5 on one pin of port E
        apb(1'b1, 3'h4, OFF_PCTL, 32'h0500);
        apb(1'b1, 3'h4, OFF_AFSEL, 32'h04);
        #1 check(pad_oe[4], 8'h00);
        apb(1'b1, 3'h4, OFF_DEN, 32'h04);
        #1 check(pad_out[4][2], 1'b1);
        check(pad_oe[4], 8'h04);
        check(alt_in[4][2], 16'h0020);
        // Refused accesses
        apb(1'b0, 3'h1, 12'h600, 32'h0);
        check(rdat, 32'h0);
        check(rerr, 1'b1);
        apb(1'b1, 3'h7, OFF_DIR, 32'hff);
        check(rerr, 1'b1);
        // Every detection mode on port F pin 0
        apb(1'b1, 3'h5, OFF_DEN, 32'h01);
        apb(1'b1, 3'h5, OFF_IM, 32'h01);
        for (int m = 0; m < 5; m++) begin
            ext_val[5][0] <= starts[m];
            apb(1'b1, 3'h5, OFF_IS, {31'h0, modes[m][2]});
            apb(1'b1, 3'h5, OFF_IBE, {31'h0, modes[m][1]});
            apb(1'b1, 3'h5, OFF_IEV, {31'h0, modes[m][0]});
            repeat (6) @(posedge pclk);
            apb(1'b1, 3'h5, OFF_ICR, 32'h01);
            #1 check(irq[5], 1'b0);
            @(posedge pclk);
            ext_val[5][0] <= ~starts[m];
            repeat (7) @(posedge pclk);
            #1 check(irq[5], 1'b1);
            apb(1'b1, 3'h5, OFF_IM, 32'h0);
            #1 check(irq[5], 1'b0);
            rd_chk(3'h5, OFF_RIS, 32'h01);
            apb(1'b1, 3'h5, OFF_IM, 32'h01);
        end
        // Level still held, so clearing cannot drop the status
        apb(1'b1, 3'h5, OFF_ICR, 32'h01);
        rd_chk(3'h5, OFF_RIS, 32'h01);
        // Reset mid-run restores the exception pins
        do_reset();
        rd_chk(3'h0, OFF_AFSEL, 32'h3f);
        rd_chk(3'h4, OFF_PCTL, 32'h0);
        rd_chk(3'h6, OFF_SLR, 32'h0);
        #1 check(irq, 7'h0);
        results();
    end
endmodule : testbench
